// ==== bench/bsq_core_model.sv ====
// Purpose : Behavioural converter core facing the sequencer
// Assumes : One powered start pulse gives one done pulse delay_in + 1 cycles later
// Notes   : Converts only while powered; data line garbles when idle

`timescale 1ns/1ps

module bsq_core_model
   import bsq_pkg::*;
(
   // Clock and reset
   input  wire logic                sys_clk_in,
   input  wire logic                rstn_in,
   // From sequencer and bench
   input  wire logic                start_in,
   input  wire logic                power_in,
   input  wire logic [7:0]          delay_in,
   input  wire logic [SAMPLE_W-1:0] value_in,
   // To sequencer
   output logic                     done_out,
   output logic [SAMPLE_W-1:0]      data_out
);
   logic [7:0] wait_q;
   logic       run_q;

   // post tracking only
   // Data is valid only with done; otherwise it flips so stale values never match
   always_ff @(posedge sys_clk_in) begin
      done_out <= 1'b0;
      if (!rstn_in) begin
         run_q    <= 1'b0;
         wait_q   <= 8'h00;
         data_out <= '0;
      end else if (start_in && power_in) begin
         run_q    <= 1'b1;
         wait_q   <= delay_in;
         data_out <= ~data_out;
      end else if (run_q && wait_q == 8'h00) begin
         run_q    <= 1'b0;
         done_out <= 1'b1;
         data_out <= value_in;
      end else begin
         wait_q   <= run_q ? wait_q - 8'h01 : wait_q;
         data_out <= ~data_out;
      end
   end
endmodule

// ==== bench/tb_top.sv ====
// Purpose : Self-checking bench for the burst sample sequencer
// Assumes : Tick divider shortened to DIV=2
// Notes   : Expected sums and counts are worked out here

`timescale 1ns/1ps

`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin miscompares++; \
   $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end

module tb_top
   import bsq_pkg::*;
;
   localparam int DIV = 2;
   logic                clk = 1'b0;
   logic                rstn, bme, cen, clr, cst, cdone, cpow, cstart, flag, busy;
   logic [PWR_W-1:0]    put;
   logic [1:0]          rpt;
   logic [SAMPLE_W-1:0] cdata, val;
   logic [ACC_W-1:0]    res;
   logic [7:0]          dly;
   int                  miscompares = 0;
   int                  samples_checked = 0;
   int                  nstart, nopow, cyc, lat, i;
   int                  cnts [4] = '{1, 4, 8, 16};

   always #2.5 clk = ~clk;

   bsq_burst_seq #(.DIV(DIV)) dut (
      .sys_clk_in(clk), .rstn_in(rstn), .burst_mode_enable_in(bme),
      .converter_enable_in(cen), .power_up_time_in(put), .repeat_count_in(rpt),
      .done_clear_in(clr), .conv_start_in(cst), .core_done_in(cdone),
      .core_data_in(cdata), .core_power_out(cpow), .core_start_out(cstart),
      .conversion_done_flag_out(flag), .result_out(res), .busy_out(busy));

   bsq_core_model core (
      .sys_clk_in(clk), .rstn_in(rstn), .start_in(cstart), .power_in(cpow),
      .delay_in(dly), .value_in(val), .done_out(cdone), .data_out(cdata));

   // Start count, first-start latency and starts seen unpowered
   always @(posedge clk) begin
      if (cst) cyc = 0;
      else cyc++;
      if (cstart === 1'b1) begin
         if (nstart == 0) lat = cyc;
         nstart++;
         if (cpow !== 1'b1) nopow++;
      end
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // One trigger, then wait for the sequencer to go idle
   task automatic do_set(input logic b, input logic e, input logic [1:0] r,
                         input logic [PWR_W-1:0] p, input logic [SAMPLE_W-1:0] v,
                         input logic [7:0] d, input logic c);
      int k;
      @(posedge clk);
      clr <= c;
      @(posedge clk);
      clr <= 1'b0;
      bme <= b;
      cen <= e;
      rpt <= r;
      put <= p;
      val <= v;
      dly <= d;
      cst <= 1'b1;
      @(posedge clk);
      cst <= 1'b0;
      nstart = 0;
      k = 0;
      @(posedge clk);
      #1;
      while (busy === 1'b1 && k < 4000) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k >= 4000) begin
         miscompares++;
         $display("[ERR] busy_idle exp 0 got 1");
      end
   endtask

   initial begin
      #(20000 * 5);
      miscompares++;
      end_sim();
   end

   initial begin
      rstn <= 1'b0; bme <= 1'b0; cen <= 1'b1; put <= '0; rpt <= 2'h0;
      clr <= 1'b0; cst <= 1'b0; dly <= 8'h00; val <= '0; nopow = 0;
      repeat (10) @(posedge clk);
      #1;
      `CHK("rst_flag", 1'b0, flag)
      `CHK("rst_result", RST_ACC, res)
      `CHK("rst_busy", 1'b0, busy)
      `CHK("rst_start", 1'b0, cstart)
      @(posedge clk);
      rstn <= 1'b1;
      $display("test reset done");

      for (i = 0; i < 4; i++) begin
         do_set(1'b1, 1'b1, i[1:0], 5'h00, 12'hfff, 8'h00, 1'b1);
         `CHK("starts", cnts[i], nstart)
         `CHK("result", 16'(cnts[i] * 12'hfff), res)
         `CHK("flag", 1'b1, flag)
         `CHK("power_kept", 1'b1, cpow)
         `CHK("quick_start", 1'b1, lat <= DIV + 2)
      end
      $display("test burst_counts done");

      // slow core, paced by the burst tick from power-down
      do_set(1'b1, 1'b0, RPT_4, 5'h1f, 12'h123, 8'h1e, 1'b1);
      `CHK("pd_starts", 4, nstart)
      `CHK("pd_result", 16'h048c, res)
      `CHK("pd_flag", 1'b1, flag)
      `CHK("pd_power_off", 1'b0, cpow)
      `CHK("pd_wait", 1'b1, lat > 125 * DIV)
      `CHK("pd_awake", 0, nopow)
      $display("test burst_powerdown done");

      // one conversion per trigger without burst
      for (i = 0; i < 4; i++) begin
         do_set(1'b0, 1'b1, RPT_4, 5'h00, 12'h010 + i[11:0], 8'h03, i == 0);
         `CHK("nb_starts", 1, nstart)
         `CHK("nb_latency", 2, lat)
         `CHK("nb_flag", i == 3, flag)
      end
      `CHK("nb_result", 16'h0046, res)
      $display("test single_mode done");

      // disabled converter outside burst ignores the trigger
      do_set(1'b0, 1'b0, RPT_1, 5'h00, 12'h555, 8'h00, 1'b1);
      `CHK("off_starts", 0, nstart)
      `CHK("off_flag", 1'b0, flag)
      `CHK("off_result", 16'h0046, res)
      `CHK("off_power", 1'b0, cpow)
      $display("test ignored_trigger done");
      end_sim();
   end
endmodule

// ==== verilog/bsq_burst_seq.sv ====
// Purpose : Burst and single conversion sequencer for the converter unit
// Assumes : Trigger, core done and core data are synchronous to sys_clk_in
// Notes   : Results are accumulated; the done flag is sticky until cleared
//
// How it works
// RULE1: Burst only while burst enable is one; here the mode is taken at the trigger and a started burst runs its full count
// RULE2: Accumulate one, four, eight or sixteen samples
// RULE3: Burst paced by own 25 MHz tick
// RULE4: Enable low powers converter down after burst
// RULE5: Enable high keeps converter powered after burst
// RULE6: Trigger in burst wakes the converter
// RULE7: Powered down: power up, then wait
// RULE8: Still enabled: convert at once, no wait
// RULE9: Software picks post or dual tracking only; this block has no tracking select input
// RULE10: One trigger runs repeat count conversions
// RULE11: Without burst, one conversion per trigger
// RULE12: Done flag only after repeat count conversions
// RULE13: Two-bit repeat count selects sample count

`timescale 1ns/1ps

module bsq_burst_seq
   import bsq_pkg::*;
#(
   parameter int DIV = BURST_DIV
) (
   // Clock and reset
   input  wire logic                sys_clk_in,
   input  wire logic                rstn_in,
   // Software control bits
   input  wire logic                burst_mode_enable_in,
   input  wire logic                converter_enable_in,
   input  wire logic [PWR_W-1:0]    power_up_time_in,
   input  wire logic [1:0]          repeat_count_in,
   input  wire logic                done_clear_in,
   // Conversion trigger
   input  wire logic                conv_start_in,
   // Converter core
   input  wire logic                core_done_in,
   input  wire logic [SAMPLE_W-1:0] core_data_in,
   output logic                     core_power_out,
   output logic                     core_start_out,
   // Status
   output logic                     conversion_done_flag_out,
   output logic [ACC_W-1:0]         result_out,
   output logic                     busy_out
);

   bsq_seq_t s_q;
   bsq_seq_t s_d;
   logic     tick;
   logic     last;
   logic     set_done;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // RULE13: repeat code to count
   function automatic logic [CNT_W-1:0] samples(input logic [1:0] code);
      logic [CNT_W-1:0] n;
      n = CNT_1;
      case (code)
         RPT_1:   n = CNT_1;
         RPT_4:   n = CNT_4;
         RPT_8:   n = CNT_8;
         RPT_16:  n = CNT_16;
         default: n = CNT_1;
      endcase
      return n;
   endfunction

   // Power-up wait in burst ticks
   function automatic logic [PCNT_W-1:0] pwr_ticks(input logic [PWR_W-1:0] t);
      return PCNT_W'(t) * PCNT_W'(PWR_STEP_TICKS);
   endfunction

   // ----------------------------------------------------------------
   // Burst pacing
   // ----------------------------------------------------------------
   // RULE3: private pacing source
   bsq_tick_gen #(
      .DIV        (DIV)
   ) u_tick (
      .sys_clk_in (sys_clk_in),
      .rstn_in    (rstn_in),
      .tick_out   (tick)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // RULE12: last conversion of the set
   assign last = (s_q.cnt + CNT_W'(1)) == samples(repeat_count_in);
   assign set_done = (s_q.state == ST_WAIT) && core_done_in && last;

   always_comb begin
      s_d       = s_q;
      s_d.start = 1'b0;
      case (s_q.state)
         ST_IDLE: begin
            if (conv_start_in) begin
               // RULE1: mode is taken at the trigger
               s_d.burst = burst_mode_enable_in;
               if (burst_mode_enable_in) begin
                  // RULE6: wake from idle power state
                  if (!converter_enable_in) begin
                     // RULE7: power up and wait
                     s_d.pcnt  = pwr_ticks(power_up_time_in);
                     s_d.state = ST_POWERUP;
                  end else begin
                     // RULE8: already enabled, no wait
                     s_d.state = ST_START;
                  end
               end else if (converter_enable_in) begin
                  // RULE11: single conversion needs an enabled core
                  s_d.state = ST_START;
               end
            end
         end
         ST_POWERUP: begin
            // RULE7: wait counted in burst ticks
            if (tick) begin
               if (s_q.pcnt == RST_PCNT) begin
                  s_d.state = ST_START;
               end else begin
                  s_d.pcnt = s_q.pcnt - PCNT_W'(1);
               end
            end
         end
         ST_START: begin
            // RULE3: burst starts land on a burst tick
            if (!s_q.burst || tick) begin
               s_d.start = 1'b1;
               s_d.state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (core_done_in) begin
               // RULE2: accumulate each sample
               if (last) begin
                  s_d.result = s_q.acc + ACC_W'(core_data_in);
                  s_d.acc    = RST_ACC;
                  s_d.cnt    = RST_CNT;
                  s_d.state  = ST_IDLE;
               end else begin
                  s_d.acc = s_q.acc + ACC_W'(core_data_in);
                  s_d.cnt = s_q.cnt + CNT_W'(1);
                  // RULE10: burst continues without a new trigger
                  // RULE11: single mode waits for the next trigger
                  s_d.state = s_q.burst ? ST_START : ST_IDLE;
               end
            end
         end
         default: begin
            s_d.state = ST_IDLE;
         end
      endcase
      // RULE12: a set beats a clear in the same cycle
      s_d.done = set_done | (s_q.done & ~done_clear_in);
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         s_q <= '{state:  ST_IDLE,
                  burst:  1'b0,
                  pcnt:   RST_PCNT,
                  cnt:    RST_CNT,
                  acc:    RST_ACC,
                  result: RST_ACC,
                  done:   1'b0,
                  start:  1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // RULE4: idle power follows enable; RULE5: enable keeps it on
   assign core_power_out           = converter_enable_in || (s_q.state != ST_IDLE);
   assign core_start_out           = s_q.start;
   assign conversion_done_flag_out = s_q.done;
   assign result_out               = s_q.result;
   assign busy_out                 = s_q.state != ST_IDLE;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   burst_start_paced_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE3
      core_start_out && s_q.burst |-> $past(tick))
      else $error("burst start not on a burst tick");

   power_kept_on_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE5
      set_done && s_q.burst && converter_enable_in |=> core_power_out && !busy_out)
      else $error("converter powered down while enabled");

   power_down_idle_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE4
      set_done && s_q.burst && !converter_enable_in |=> !core_power_out)
      else $error("converter not powered down after burst");

   wake_with_wait_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE7
      s_q.state == ST_IDLE && conv_start_in && burst_mode_enable_in
      && !converter_enable_in
      |=> s_q.state == ST_POWERUP && s_q.pcnt == pwr_ticks($past(power_up_time_in)))
      else $error("power-up wait not started");

   wake_no_wait_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE8
      s_q.state == ST_IDLE && conv_start_in && burst_mode_enable_in
      && converter_enable_in |=> s_q.state == ST_START)
      else $error("enabled converter did not start at once");

   flag_on_count_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE12
      s_q.state == ST_WAIT && core_done_in && last |=> conversion_done_flag_out)
      else $error("done flag missing after repeat count");

   no_early_flag_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE12
      s_q.state == ST_WAIT && core_done_in && !last && !s_q.done
      |=> !conversion_done_flag_out)
      else $error("done flag raised early");

   single_per_trig_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE11
      s_q.state == ST_WAIT && core_done_in && !last && !s_q.burst
      |=> s_q.state == ST_IDLE ##1 !core_start_out)
      else $error("single mode converted without a trigger");

   burst_continues_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE10
      s_q.state == ST_WAIT && core_done_in && !last && s_q.burst
      |=> s_q.state == ST_START ##[1:16] core_start_out)
      else $error("burst stopped before repeat count");

   sum_taken_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE2
      set_done |=> result_out == $past(s_q.acc) + ACC_W'($past(core_data_in)))
      else $error("accumulated result wrong");

   mode_latched_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE1
      s_q.state == ST_IDLE && conv_start_in && (burst_mode_enable_in || converter_enable_in)
      |=> s_q.burst == $past(burst_mode_enable_in))
      else $error("mode not taken at the trigger");

   single_taken_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE11
      s_q.state == ST_IDLE && conv_start_in && !burst_mode_enable_in && converter_enable_in
      |=> s_q.state == ST_START ##1 core_start_out)
      else $error("single conversion not started");

   off_trig_ignored_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE11
      s_q.state == ST_IDLE && conv_start_in && !burst_mode_enable_in && !converter_enable_in
      |=> s_q.state == ST_IDLE)
      else $error("trigger taken with converter disabled");

   idle_no_start_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE11
      s_q.state == ST_IDLE |=> !core_start_out)
      else $error("conversion started from idle");

   powerup_quiet_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE7
      s_q.state == ST_POWERUP |-> !core_start_out && core_power_out)
      else $error("conversion during power-up wait");

   powerup_count_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE7
      s_q.state == ST_POWERUP && tick && s_q.pcnt != RST_PCNT
      |=> s_q.state == ST_POWERUP && s_q.pcnt == $past(s_q.pcnt) - PCNT_W'(1))
      else $error("power-up wait not counted down");

   powerup_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE7
      s_q.state == ST_POWERUP && !tick |=> s_q.state == ST_POWERUP && $stable(s_q.pcnt))
      else $error("power-up wait moved without a tick");

   powerup_end_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE7
      s_q.state == ST_POWERUP && tick && s_q.pcnt == RST_PCNT |=> s_q.state == ST_START)
      else $error("power-up wait did not end");

   wait_for_done_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE10
      s_q.state == ST_WAIT && !core_done_in |=> s_q.state == ST_WAIT && !core_start_out)
      else $error("left the wait without a core done");

   accum_step_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE2
      s_q.state == ST_WAIT && core_done_in && !last
      |=> s_q.acc == $past(s_q.acc) + ACC_W'($past(core_data_in)))
      else $error("sample not accumulated");

   set_cleared_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE2
      set_done |=> s_q.cnt == RST_CNT && s_q.acc == RST_ACC && !busy_out)
      else $error("accumulator not cleared after a set");

   result_held_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE12
      !set_done |=> $stable(result_out))
      else $error("result changed before the set ended");

   flag_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE12
      done_clear_in && !set_done |=> !conversion_done_flag_out)
      else $error("done flag not cleared");

   flag_sticky_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE12
      conversion_done_flag_out && !done_clear_in |=> conversion_done_flag_out)
      else $error("done flag dropped without a clear");

   count_in_range_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE13
      s_q.state == ST_WAIT |-> s_q.cnt < samples(repeat_count_in))
      else $error("sample count beyond repeat count");

endmodule

// ==== verilog/bsq_pkg.sv ====
// Purpose : Shared constants and types for the burst sample sequencer
// Assumes : 200 MHz system clock, burst pacing derived inside the block
// Notes   : All offsets, reset values and cycle counts live here

package bsq_pkg;

   // ----------------------------------------------------------------
   // Clock and pacing
   // ----------------------------------------------------------------
   localparam int SYS_PERIOD_PS   = 5000;
   localparam int BURST_PERIOD_PS = 40000;
   // Longest spacing rounds down, never below one cycle
   localparam int BURST_DIV       = (BURST_PERIOD_PS / SYS_PERIOD_PS) < 1 ? 1 :
                                    (BURST_PERIOD_PS / SYS_PERIOD_PS);
   localparam int DIV_W           = 4;
   localparam logic [DIV_W-1:0] RST_DIV_CNT = 4'h0;

   // ----------------------------------------------------------------
   // Widths and reset values
   // ----------------------------------------------------------------
   localparam int SAMPLE_W = 12;
   localparam int ACC_W    = 16;
   localparam int PWR_W    = 5;
   localparam int PCNT_W   = 8;
   localparam int CNT_W    = 5;
   // Burst ticks per step of the power-up time field
   localparam logic [2:0]        PWR_STEP_TICKS = 3'h4;
   localparam logic [ACC_W-1:0]  RST_ACC        = 16'h0000;
   localparam logic [PCNT_W-1:0] RST_PCNT       = 8'h00;
   localparam logic [CNT_W-1:0]  RST_CNT        = 5'h00;

   // ----------------------------------------------------------------
   // Repeat count codes and sample counts
   // ----------------------------------------------------------------
   localparam logic [1:0] RPT_1  = 2'h0;
   localparam logic [1:0] RPT_4  = 2'h1;
   localparam logic [1:0] RPT_8  = 2'h2;
   localparam logic [1:0] RPT_16 = 2'h3;
   localparam logic [CNT_W-1:0] CNT_1  = 5'h01;
   localparam logic [CNT_W-1:0] CNT_4  = 5'h04;
   localparam logic [CNT_W-1:0] CNT_8  = 5'h08;
   localparam logic [CNT_W-1:0] CNT_16 = 5'h10;

   // ----------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_POWERUP,
      ST_START,
      ST_WAIT
   } bsq_state_t;

   typedef struct packed {
      bsq_state_t        state;
      logic              burst;
      logic [PCNT_W-1:0] pcnt;
      logic [CNT_W-1:0]  cnt;
      logic [ACC_W-1:0]  acc;
      logic [ACC_W-1:0]  result;
      logic              done;
      logic              start;
   } bsq_seq_t;

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             tick;
   } bsq_tick_t;

endpackage

// ==== verilog/bsq_tick_gen.sv ====
// Purpose : Burst pacing tick, one pulse every DIV system clocks
// Assumes : Runs from reset onward, never stops
// Notes   : Stands in for the private burst oscillator

`timescale 1ns/1ps

module bsq_tick_gen
   import bsq_pkg::*;
#(
   parameter int DIV = BURST_DIV
) (
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic rstn_in,
   // Pacing
   output logic      tick_out
);

   bsq_tick_t s_q;
   bsq_tick_t s_d;

   // ----------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------
   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == DIV_W'(DIV - 1)) begin
         s_d.cnt  = RST_DIV_CNT;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + DIV_W'(1);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         s_q <= '{cnt: RST_DIV_CNT, tick: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_out = s_q.tick;

   tick_spacing_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // RULE3
      tick_out && DIV > 1 |=> !tick_out)
      else $error("burst tick repeated too soon");

endmodule
